// *** ledspi_pkg.sv ***
// constants and types for the led driver serial register slave
package ledspi_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_FAULT     = 5'h01;
  localparam logic [4:0] ADDR_RW_FIRST  = 5'h02;
  localparam logic [4:0] ADDR_RW_LAST   = 5'h08;
  localparam logic [4:0] ADDR_TEMP      = 5'h09;
  localparam logic [4:0] ADDR_CH1_LATE  = 5'h0a;
  localparam logic [4:0] ADDR_CH1_ON    = 5'h0b;
  localparam logic [4:0] ADDR_CH1_OFF   = 5'h0c;
  localparam logic [4:0] ADDR_CH2_LATE  = 5'h0d;
  localparam logic [4:0] ADDR_CH2_ON    = 5'h0e;
  localparam logic [4:0] ADDR_CH2_OFF   = 5'h0f;
  localparam logic [4:0] ADDR_RESTART   = 5'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_CH1_EN   = 0;
  localparam int CTRL_CH2_EN   = 1;
  localparam int CTRL_CH1_SMP  = 2;
  localparam int CTRL_CH2_SMP  = 3;
  localparam int CTRL_TEMP_SMP = 4;
  localparam int FLT_SPI_ERR   = 0;
  localparam int FLT_TEMP_WARN = 1;
  localparam int FLT_CH1_BOOT  = 2;
  localparam int FLT_CH2_BOOT  = 3;
  localparam int FLT_POWER_ON  = 4;

  // ****************************************
  // reset values and frames
  // ****************************************
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [4:0]  FAULT_RST  = 5'h10;
  localparam logic [8:0]  LIMIT_RST  = 9'h080;
  localparam logic [8:0]  PEAK_RST   = 9'h080;
  localparam logic [8:0]  OTHER_RST  = 9'h000;
  localparam logic [8:0]  NARROW_MSK = 9'h0ff;
  localparam logic [8:0]  WIDE_MSK   = 9'h1ff;
  localparam logic [15:0] ERR_FRAME  = 16'h8000;
  localparam logic [1:0]  RD_RSVD    = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ    = 10;
  localparam int SAMPLE_US  = 100;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam logic [9:0] TMR_LAST = 10'(SAMPLE_CYC - 1);

  // ****************************************
  // synchroniser lanes
  // ****************************************
  localparam int SY_SCK  = 0;
  localparam int SY_SSN  = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_PWM1 = 3;
  localparam int SY_PWM2 = 4;
  localparam int SY_BYP  = 5;
  localparam int SY_UV1  = 6;
  localparam int SY_UV2  = 7;
  localparam int SY_W    = 8;
  localparam logic [7:0] SY_RST = 8'h02;

  // adc input slots: 0 ch1 voltage, 1 ch2 voltage, 2 die temp
  localparam logic [1:0] SRC_TEMP = 2'h2;

  typedef enum logic {SQ_IDLE, SQ_CONV} ledspi_seq_e;

endpackage

// *** ledspi_top.sv ***
// serial register slave of a dual channel led driver
`timescale 1ns/1ps
module ledspi_top
  import ledspi_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sck,
  input  wire logic       i_select_low_n,
  input  wire logic       i_mosi,
  output logic            o_miso,
  output logic            o_miso_oe,
  input  wire logic       i_ch1_dimming_input_pin,
  input  wire logic       i_ch2_dimming_input_pin,
  input  wire logic       i_enable_undervoltage_bypass,
  input  wire logic       i_ch1_boot_low,
  input  wire logic       i_ch2_boot_low,
  input  wire logic [8:0] i_adc_result,
  output logic [1:0]      o_adc_select,
  output logic            o_adc_start,
  output logic            o_ch1_run,
  output logic            o_ch2_run,
  output logic            o_ch1_pulldown,
  output logic            o_ch2_pulldown,
  output logic [8:0]      o_ch1_peak_thr,
  output logic [8:0]      o_ch2_peak_thr,
  output logic [8:0]      o_ch1_off_time,
  output logic [8:0]      o_ch2_off_time,
  output logic [8:0]      o_ch1_max_off,
  output logic [8:0]      o_ch2_max_off,
  output logic            o_soft_restart
);

  // ****************************************
  // functions
  // ****************************************

  // storage mask of the read-write bank
  function automatic logic [8:0] rw_mask(input int idx);
    return (idx <= 2) ? NARROW_MSK : WIDE_MSK;
  endfunction

  // reset value of the read-write bank
  function automatic logic [8:0] rw_reset(input int idx);
    if (idx == 0) begin
      return LIMIT_RST;
    end
    return (idx <= 2) ? PEAK_RST : OTHER_RST;
  endfunction

  // nearest enabled slot after cur, in rotation
  function automatic logic [1:0] next_src(input logic [1:0] cur,
                                          input logic [2:0] en);
    logic [1:0] r;
    logic [1:0] c;
    r = cur;
    for (int k = 3; k >= 1; k--) begin
      c = 2'((int'(cur) + k) % 3);
      if (en[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [SY_W-1:0] pin_w;
  logic [SY_W-1:0] s1_q;
  logic [SY_W-1:0] s2_q;
  logic [SY_W-1:0] s3_q;
  logic [SY_W-1:0] f_q;
  logic [SY_W-1:0] f_d;
  logic [SY_W-1:0] rise;
  logic [SY_W-1:0] fall;

  assign pin_w = {i_ch2_boot_low, i_ch1_boot_low,
                  i_enable_undervoltage_bypass,
                  i_ch2_dimming_input_pin, i_ch1_dimming_input_pin,
                  i_mosi, i_select_low_n, i_sck};

  // three stage chain per lane
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= SY_RST;
      s2_q <= SY_RST;
      s3_q <= SY_RST;
      f_q  <= SY_RST;
    end else begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  // a lane changes once stages two and three agree
  assign f_d  = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
  assign rise = f_d & ~f_q;
  assign fall = ~f_d & f_q;

  // ****************************************
  // serial shift path
  // ****************************************
  logic        active;
  logic        sck_rise;
  logic        sck_fall;
  logic        ssn_fall;
  logic        ssn_rise;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic [15:0] resp_q;
  logic [3:0]  cnt_q;
  logic        seen_q;
  logic        oe_q;

  assign active   = ~f_q[SY_SSN];
  assign sck_rise = active & rise[SY_SCK];
  assign sck_fall = active & fall[SY_SCK] & seen_q;
  assign ssn_fall = fall[SY_SSN];
  assign ssn_rise = rise[SY_SSN];

  // receive on rising clock, msb first
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q   <= 16'h0000;
      cnt_q  <= 4'h0;
      seen_q <= 1'b0;
    end else if (ssn_fall) begin
      cnt_q  <= 4'h0;
      seen_q <= 1'b0;
    end else if (sck_rise) begin
      rx_q   <= {rx_q[14:0], f_q[SY_MOSI]};
      cnt_q  <= cnt_q + 4'h1;
      seen_q <= 1'b1;
    end
  end

  // transmit: load at select fall, shift on falling clock
  always_comb begin
    tx_d = tx_q;
    if (ssn_fall) begin
      tx_d = resp_q;
    end else if (sck_fall) begin
      tx_d = {tx_q[14:0], rx_q[15]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_q <= ERR_FRAME;
      oe_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      oe_q <= ~f_d[SY_SSN] & ~tx_d[15];
    end
  end

  // open drain: pull low only for a zero bit
  assign o_miso    = 1'b0;
  assign o_miso_oe = oe_q;

  // ****************************************
  // frame decode at select rise
  // ****************************************
  logic       cmd_w;
  logic [4:0] addr_w;
  logic [8:0] data_w;
  logic       frame_err;
  logic       wr_ok;
  logic       rd_go;
  logic [8:0] rd_mux;

  assign cmd_w  = rx_q[15];
  assign addr_w = rx_q[14:10];
  assign data_w = rx_q[8:0];

  // length, parity and read data checks
  assign frame_err = ~seen_q | (cnt_q != 4'h0)
                   | ~(^rx_q)
                   | (~cmd_w & (|data_w));
  assign wr_ok = ssn_rise & cmd_w & ~frame_err;
  assign rd_go = ssn_rise & ~cmd_w;

  // ****************************************
  // register storage
  // ****************************************
  logic [4:0] ctrl_q;
  logic [4:0] fault_q;
  logic [4:0] fault_d;
  logic [4:0] cond_w;
  logic [8:0] rw_q [7];
  logic [8:0] temp_q;
  logic [8:0] late_q [2];
  logic [8:0] on_q [2];
  logic [8:0] off_q [2];
  logic       temp_hot;
  logic       restart_q;

  // control register write
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ok && addr_w == ADDR_CTRL) begin
      ctrl_q <= data_w[4:0];
    end
  end

  // read-write bank at 2h to 8h
  for (genvar i = 0; i < 7; i++) begin : g_rw
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        rw_q[i] <= rw_reset(i);
      end else if (wr_ok && addr_w == ADDR_RW_FIRST + 5'(i)) begin
        rw_q[i] <= data_w & rw_mask(i);
      end
    end
  end

  // restart command pulse
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ok && addr_w == ADDR_RESTART;
    end
  end
  assign o_soft_restart = restart_q;

  // ****************************************
  // fault status
  // ****************************************
  assign temp_hot = temp_q > {1'b0, rw_q[0][7:0]};
  assign cond_w   = {1'b0, f_q[SY_UV2], f_q[SY_UV1], temp_hot, 1'b0};

  // set wins over the read clear; held flags stay while present
  always_comb begin
    fault_d = fault_q;
    if (rd_go && addr_w == ADDR_FAULT) begin
      fault_d = fault_q & cond_w;
    end
    fault_d = fault_d | cond_w;
    fault_d[FLT_SPI_ERR] = fault_d[FLT_SPI_ERR]
                         | (ssn_rise & frame_err);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_q <= FAULT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // ****************************************
  // read mux and response
  // ****************************************
  always_comb begin
    rd_mux = 9'h000;
    case (addr_w)
      ADDR_CTRL:     rd_mux = {4'h0, ctrl_q};
      ADDR_FAULT:    rd_mux = {4'h0, fault_q};
      ADDR_TEMP:     rd_mux = temp_q;
      ADDR_CH1_LATE: rd_mux = late_q[0];
      ADDR_CH1_ON:   rd_mux = on_q[0];
      ADDR_CH1_OFF:  rd_mux = off_q[0];
      ADDR_CH2_LATE: rd_mux = late_q[1];
      ADDR_CH2_ON:   rd_mux = on_q[1];
      ADDR_CH2_OFF:  rd_mux = off_q[1];
      default: begin
        if (addr_w >= ADDR_RW_FIRST && addr_w <= ADDR_RW_LAST) begin
          rd_mux = rw_q[3'(addr_w - ADDR_RW_FIRST)];
        end
      end
    endcase
  end

  // next response picked by the frame just ended
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resp_q <= ERR_FRAME;
    end else if (ssn_rise) begin
      if (!cmd_w) begin
        resp_q <= {frame_err, RD_RSVD, fault_q[4:1],
                   rd_mux};
      end else if (frame_err) begin
        resp_q <= ERR_FRAME;
      end else begin
        resp_q <= {1'b0, cmd_w, addr_w,
                   data_w};
      end
    end
  end

  // ****************************************
  // adc sampling sequencer
  // ****************************************
  ledspi_seq_e seq_q;
  logic [1:0]  sel_q;
  logic [9:0]  tmr_q;
  logic        start_q;
  logic [2:0]  smp_en;
  logic        done_w;

  assign smp_en = {ctrl_q[CTRL_TEMP_SMP], ctrl_q[CTRL_CH2_SMP],
                   ctrl_q[CTRL_CH1_SMP]};
  assign done_w = (seq_q == SQ_CONV) && (tmr_q == TMR_LAST);

  // one slot per conversion, rotating over enabled inputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_q   <= SQ_IDLE;
      sel_q   <= 2'h0;
      tmr_q   <= 10'h000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (seq_q)
        SQ_IDLE: begin
          if (|smp_en) begin
            sel_q   <= next_src(SRC_TEMP, smp_en);
            tmr_q   <= 10'h000;
            start_q <= 1'b1;
            seq_q   <= SQ_CONV;
          end
        end
        SQ_CONV: begin
          if (tmr_q != TMR_LAST) begin
            tmr_q <= tmr_q + 10'h001;
          end else if (|smp_en) begin
            sel_q   <= next_src(sel_q, smp_en);
            tmr_q   <= 10'h000;
            start_q <= 1'b1;
          end else begin
            seq_q <= SQ_IDLE;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end
  assign o_adc_select = sel_q;
  assign o_adc_start  = start_q;

  // temperature result capture
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_q <= 9'h000;
    end else if (done_w && sel_q == SRC_TEMP) begin
      temp_q <= i_adc_result;
    end
  end

  // per channel latest, last-on and last-off voltages
  for (genvar c = 0; c < 2; c++) begin : g_volt
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        late_q[c] <= 9'h000;
        on_q[c]   <= 9'h000;
        off_q[c]  <= 9'h000;
      end else begin
        if (done_w && sel_q == 2'(c)) begin
          late_q[c] <= i_adc_result;
        end
        if (fall[SY_PWM1 + c]) begin
          on_q[c] <= late_q[c];
        end
        if (rise[SY_PWM1 + c]) begin
          off_q[c] <= late_q[c];
        end
      end
    end
  end

  // ****************************************
  // channel control outputs
  // ****************************************
  logic       byp;
  logic [1:0] pwm_w;
  logic [1:0] en_w;
  logic [1:0] run_q;
  logic [1:0] pd_q;
  logic [8:0] dac_q [6];

  assign byp   = f_q[SY_BYP];
  assign pwm_w = {f_q[SY_PWM2], f_q[SY_PWM1]};
  assign en_w  = {ctrl_q[CTRL_CH2_EN], ctrl_q[CTRL_CH1_EN]};

  // run gating and pull-down, bypass ignores the enables
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 2'h0;
      pd_q  <= 2'h3;
    end else begin
      run_q <= pwm_w & (en_w | {2{byp}});
      pd_q  <= ~en_w & ~{2{byp}};
    end
  end
  assign o_ch1_run      = run_q[0];
  assign o_ch2_run      = run_q[1];
  assign o_ch1_pulldown = pd_q[0];
  assign o_ch2_pulldown = pd_q[1];

  // converter set points, defaults while bypassed
  for (genvar d = 0; d < 6; d++) begin : g_dac
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        dac_q[d] <= rw_reset(d + 1);
      end else begin
        dac_q[d] <= byp ? rw_reset(d + 1) : rw_q[d + 1];
      end
    end
  end
  assign o_ch1_peak_thr = dac_q[0];
  assign o_ch2_peak_thr = dac_q[1];
  assign o_ch1_off_time = dac_q[2];
  assign o_ch2_off_time = dac_q[3];
  assign o_ch1_max_off  = dac_q[4];
  assign o_ch2_max_off  = dac_q[5];

endmodule

// *** ledspi_top_properties.sv ***
// port checker for the led driver serial register slave
`timescale 1ns/1ps
module ledspi_top_props (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       i_select_low_n,
  input wire logic       i_ch1_dimming_input_pin,
  input wire logic       i_ch2_dimming_input_pin,
  input wire logic       i_enable_undervoltage_bypass,
  input wire logic       o_miso_oe,
  input wire logic [1:0] o_adc_select,
  input wire logic       o_adc_start,
  input wire logic       o_ch1_run,
  input wire logic       o_ch2_run,
  input wire logic       o_ch1_pulldown,
  input wire logic       o_ch2_pulldown,
  input wire logic [8:0] o_ch1_peak_thr,
  input wire logic       o_soft_restart
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // slot spacing helper
  // ****************************************
  logic [9:0] gap_q;
  logic       seen_q;

  // cycles since the last conversion start
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_q  <= 10'h000;
      seen_q <= 1'b0;
    end else if (o_adc_start) begin
      gap_q  <= 10'h000;
      seen_q <= 1'b1;
    end else if (gap_q != 10'h3ff) begin
      gap_q <= gap_q + 10'h001;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  sequence s_sel_idle;
    i_select_low_n [*8];
  endsequence
  sequence s_dim1_low;
    !i_ch1_dimming_input_pin [*8];
  endsequence
  sequence s_bypass_on;
    (i_enable_undervoltage_bypass && i_ch1_dimming_input_pin) [*8];
  endsequence

  property p_miso_release;
    s_sel_idle |-> !o_miso_oe;
  endproperty
  property p_oe_start;
    $rose(o_miso_oe) |-> !$past(i_select_low_n, 3);
  endproperty
  property p_dim1_off;
    s_dim1_low |-> !o_ch1_run;
  endproperty
  property p_dim2_off;
    (!i_ch2_dimming_input_pin) [*8] |-> !o_ch2_run;
  endproperty
  property p_bypass_run;
    s_bypass_on |-> o_ch1_run && !o_ch1_pulldown && !o_ch2_pulldown;
  endproperty
  property p_pd_run;
    o_ch1_pulldown [*3] |-> !o_ch1_run;
  endproperty
  property p_adc_gap;
    o_adc_start && seen_q |-> gap_q >= 10'h3e7;
  endproperty
  property p_adc_slot;
    o_adc_start |=> (!o_adc_start && o_adc_select != 2'h3) [*8];
  endproperty
  property p_restart;
    o_soft_restart |-> i_select_low_n ##1 !o_soft_restart;
  endproperty
  property p_thr_hold;
    $changed(o_ch1_peak_thr) |-> $past(i_select_low_n, 3)
      || $past(i_enable_undervoltage_bypass, 6)
      || i_enable_undervoltage_bypass;
  endproperty

  a_miso_release: assert property (p_miso_release)
    else $error("serial output held while deselected");
  a_oe_start: assert property (p_oe_start)
    else $error("serial output driven without select");
  a_dim1_off: assert property (p_dim1_off)
    else $error("channel 1 runs with dimming pin low");
  a_dim2_off: assert property (p_dim2_off)
    else $error("channel 2 runs with dimming pin low");
  a_bypass_run: assert property (p_bypass_run)
    else $error("bypass did not override the enables");
  a_pd_run: assert property (p_pd_run)
    else $error("channel runs with pull-down on");
  a_adc_gap: assert property (p_adc_gap)
    else $error("conversion slot too short");
  a_adc_slot: assert property (p_adc_slot)
    else $error("bad conversion input or start");
  a_restart: assert property (p_restart)
    else $error("restart pulse malformed");
  a_thr_hold: assert property (p_thr_hold)
    else $error("set point changed outside frame decode");
endmodule

bind ledspi_top ledspi_top_props u_props (
  .i_sys_clk,
  .i_rst_n,
  .i_select_low_n,
  .i_ch1_dimming_input_pin,
  .i_ch2_dimming_input_pin,
  .i_enable_undervoltage_bypass,
  .o_miso_oe,
  .o_adc_select,
  .o_adc_start,
  .o_ch1_run,
  .o_ch2_run,
  .o_ch1_pulldown,
  .o_ch2_pulldown,
  .o_ch1_peak_thr,
  .o_soft_restart
);

// *** ledspi_master.sv ***
// serial bus master model for the led driver slave
`timescale 1ns/1ps
module ledspi_master (
  input  wire logic i_sys_clk,
  input  wire logic i_miso_line,
  output logic      o_sck,
  output logic      o_select_low_n,
  output logic      o_mosi
);
  // idle bus at time zero
  initial begin
    o_sck          = 1'b0;
    o_select_low_n = 1'b1;
    o_mosi         = 1'b0;
  end

  // let n system clocks pass
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // one transfer; the command rides in the last sixteen clocks
  task automatic xfer(input int n, input logic wr, input logic [4:0] adr,
                      input logic [8:0] dat, input logic flip,
                      output logic [15:0] resp);
    logic [15:0] frm;
    frm  = {wr, adr, ~^{wr, adr, dat} ^ flip, dat};
    resp = 16'h0000;
    wait_clk(1);
    o_select_low_n <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < n; i++) begin
      o_mosi <= (i < n - 16) ? 1'b0 : frm[n - 1 - i];
      wait_clk(4);
      o_sck <= 1'b1;
      wait_clk(4);
      if (i < 16) begin
        resp[15 - i] = i_miso_line;
      end
      o_sck <= 1'b0;
    end
    wait_clk(4);
    o_select_low_n <= 1'b1;
    o_mosi         <= ~o_mosi; // released line shows no stale bit
    wait_clk(12);
  endtask
endmodule

// *** ledspi_top_test.sv ***
// self-checking bench for the led driver serial register slave
`timescale 1ns/1ps
module ledspi_top_test
  import ledspi_pkg::*;
;
  logic       i_sys_clk, i_rst_n, i_ch1_dimming_input_pin;
  logic       i_ch2_dimming_input_pin, i_enable_undervoltage_bypass;
  logic       i_ch1_boot_low, i_ch2_boot_low;
  logic [8:0] i_adc_result;
  wire        i_sck, i_select_low_n, i_mosi, o_miso, o_miso_oe;
  wire        o_ch1_run, o_ch2_run, o_ch1_pulldown, o_ch2_pulldown;
  wire        o_soft_restart;
  wire  [8:0] o_ch1_peak_thr, o_ch1_max_off;
  wire        miso_line = o_miso_oe ? o_miso : 1'b1; // pull-up
  int         miscompares, num_checks, restarts;

  ledspi_top dut (
    .i_sys_clk, .i_rst_n, .i_sck, .i_select_low_n, .i_mosi,
    .o_miso, .o_miso_oe, .i_ch1_dimming_input_pin,
    .i_ch2_dimming_input_pin, .i_enable_undervoltage_bypass,
    .i_ch1_boot_low, .i_ch2_boot_low, .i_adc_result,
    .o_adc_select(), .o_adc_start(), .o_ch1_run, .o_ch2_run,
    .o_ch1_pulldown, .o_ch2_pulldown, .o_ch1_peak_thr,
    .o_ch2_peak_thr(), .o_ch1_off_time(), .o_ch2_off_time(),
    .o_ch1_max_off, .o_ch2_max_off(), .o_soft_restart
  );

  ledspi_master u_master (
    .i_sys_clk,
    .i_miso_line    (miso_line),
    .o_sck          (i_sck),
    .o_select_low_n (i_select_low_n),
    .o_mosi         (i_mosi)
  );

  // ****************************************
  // clock, pulse counter and compares
  // ****************************************
  always #50 i_sys_clk = ~i_sys_clk;

  // count restart pulses
  always @(posedge i_sys_clk) begin
    if (o_soft_restart === 1'b1) restarts++;
  end

  task automatic check_frame(input string nm, input logic [15:0] exp,
                             input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_pin(input string nm, input logic [8:0] exp,
                           input logic [8:0] got);
    check_frame(nm, {7'h00, exp}, {7'h00, got});
  endtask

  // one transfer and a compare of the response it brings back
  task automatic frame(input int n, input logic w, input logic [4:0] a,
                       input logic [8:0] d, input logic flip,
                       input logic [15:0] exp);
    logic [15:0] r;
    u_master.xfer(n, w, a, d, flip, r);
    check_frame("response", exp, r);
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    i_rst_n = 1'b0;
    i_ch1_dimming_input_pin = 1'b1;
    i_ch2_dimming_input_pin = 1'b0;
    i_enable_undervoltage_bypass = 1'b0;
    i_ch1_boot_low = 1'b0;
    i_ch2_boot_low = 1'b0;
    i_adc_result = 9'h055;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    check_pin("pulldown", 9'h001, {8'h00, o_ch1_pulldown});
    check_pin("run", 9'h000, {8'h00, o_ch1_run});
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, ERR_FRAME);
    frame(16, 1'h0, ADDR_FAULT, 9'h000, 1'h0, 16'h7000);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'h7010);
    frame(16, 1'h1, ADDR_CTRL, 9'h1ff, 1'h0, 16'h6000);
    frame(16, 1'h1, 5'h03, 9'h0a5, 1'h0, 16'h41ff);
    check_pin("run1", 9'h001, {8'h00, o_ch1_run});
    check_pin("run2", 9'h000, {8'h00, o_ch2_run});
    check_pin("pulldown2", 9'h000, {8'h00, o_ch2_pulldown});
    check_pin("peak", 9'h0a5, o_ch1_peak_thr);
    frame(16, 1'h1, ADDR_CTRL, 9'h003, 1'h1, 16'h46a5);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, ERR_FRAME);
    frame(16, 1'h0, ADDR_FAULT, 9'h001, 1'h0, 16'h601f);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'he001);
    frame(16, 1'h0, ADDR_FAULT, 9'h000, 1'h0, 16'h601f);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'h6001);
    frame(17, 1'h1, ADDR_CTRL, 9'h000, 1'h0, 16'h601f);
    check_pin("pulldown", 9'h000, {8'h00, o_ch1_pulldown});
    frame(32, 1'h1, ADDR_CTRL, 9'h000, 1'h0, ERR_FRAME);
    check_pin("pulldown", 9'h001, {8'h00, o_ch1_pulldown});
    i_ch1_boot_low <= 1'b1;
    frame(16, 1'h0, ADDR_FAULT, 9'h000, 1'h0, 16'h4000);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'h6405);
    frame(16, 1'h0, ADDR_FAULT, 9'h000, 1'h0, 16'h6400);
    i_ch1_boot_low <= 1'b0;
    frame(16, 1'h0, ADDR_FAULT, 9'h000, 1'h0, 16'h6404);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'h6404);
    frame(16, 1'h1, ADDR_RESTART, 9'h000, 1'h0, 16'h6000);
    frame(16, 1'h0, ADDR_CTRL, 9'h000, 1'h0, 16'h6000);
    check_pin("restarts", 9'h001, 9'(restarts));
    frame(16, 1'h0, ADDR_CH1_LATE, 9'h000, 1'h0, 16'h6000);
    frame(16, 1'h1, 5'h07, 9'h1a5, 1'h0, 16'h6055);
    check_pin("max_off", 9'h1a5, o_ch1_max_off);
    i_enable_undervoltage_bypass <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    check_pin("run1", 9'h001, {8'h00, o_ch1_run});
    check_pin("pulldown", 9'h000, {8'h00, o_ch1_pulldown});
    check_pin("peak", PEAK_RST, o_ch1_peak_thr);
    check_pin("max_off", OTHER_RST, o_ch1_max_off);
    i_ch1_dimming_input_pin <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    check_pin("run1", 9'h000, {8'h00, o_ch1_run});
    report_and_stop();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
